// ==== verif/bus_mem_model.sv ====
// system bus memory answering line reads after a random wait
`timescale 1ns/100ps
module bus_mem_model (
    input  wire logic        clk,
    input  wire logic        mem_rd_valid,
    input  wire logic [29:0] mem_rd_addr,
    input  wire logic        mem_rd_core,
    output logic             mem_done,
    output logic      [63:0] mem_rdata
);
    int wait_cnt = 0;
    initial mem_done = 1'h0;
    initial mem_rdata = 64'h0;
    // idle data toggles so a stale word is never taken for a good one
    always @(negedge clk)
    begin
        mem_done <= wait_cnt == 1;
        mem_rdata <= (wait_cnt == 1) ? {33'h0, mem_rd_core, mem_rd_addr} ^ 64'hc3a5_0f96_1e2d_4b78 : ~mem_rdata;
        wait_cnt <= mem_rd_valid ? int'($urandom_range(6, 1)) : (wait_cnt > 0 ? wait_cnt - 1 : 0);
    end
endmodule : bus_mem_model

// ==== verif/l2_share_ctrl_tb.sv ====
// random traffic from both cores, corner traffic from core 0
`timescale 1ns/100ps
module l2_share_ctrl_tb;
    logic        clk = 1'h0, rstn = 1'h0, ce = 1'h1;
    logic        mem_done, mem_rd_valid, mem_rd_core, mem_wb_valid;
    logic [1:0]  req_valid = 2'h0, req_store, l2_hit, victim_dirty, own_state [2], peer_state [2];
    logic [1:0]  req_ready, resp_valid, l1_wr_en, peer_invalidate, peer_share, l1_wr_state [2];
    logic [29:0] req_addr [2], victim_addr [2], l1_wr_addr [2], mem_rd_addr, mem_wb_addr;
    logic [63:0] req_wdata [2], own_rdata [2], peer_rdata [2], l2_rdata [2], victim_data [2];
    logic [63:0] resp_data [2], l1_wr_data [2], mem_rdata, mem_wb_data;
    int          bad_count = 0, n_compared = 0;
    always #12.5 clk = ~clk;
    l2_share_ctrl u_l2_share_ctrl (.*);
    bus_mem_model u_bus_mem_model (.*);
    // victim words are built from their address, so the pairing on the bus can be judged
    always @(negedge clk)
        if (mem_wb_valid === 1'h1) check(mem_wb_data, {34'h0, mem_wb_addr} ^ 64'h1f2e_3d4c_5b6a_7988);
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) bad_count++;
        if (got !== exp) $display("Error at %0t got %h expected %h", $time, got, exp);
    endtask : check
    task automatic stop_if(input bit hung);
        if (hung) bad_count++;
        if (hung) give_verdict();
    endtask : stop_if
    task automatic set_core(input int c, input int sto, input int os, input int ps);
        req_store[c] = sto < 0 ? 1'($urandom) : 1'(sto);
        own_state[c] = os < 0 ? 2'($urandom) : 2'(os);
        peer_state[c] = ps < 0 ? 2'($urandom) : 2'(ps);
        {l2_hit[c], victim_dirty[c]} = 2'($urandom);
        {req_addr[c], victim_addr[c]} = 60'({$urandom, $urandom});
        {req_wdata[c], own_rdata[c]} = {$urandom, $urandom, $urandom, $urandom};
        {peer_rdata[c], l2_rdata[c]} = {$urandom, $urandom, $urandom, $urandom};
        victim_data[c] = {34'h0, victim_addr[c]} ^ 64'h1f2e_3d4c_5b6a_7988;
    endtask : set_core
    task automatic access(input int c, input int sto, input int os, input int ps);
        logic [63:0] d;
        logic [1:0]  s;
        logic        w;
        int          n;
        @(negedge clk);
        set_core(c, sto, os, ps);
        req_valid[c] = 1'h1;
        n = 0;
        #1;
        // ready is judged away from the edge, never mixed up with the state a take causes
        while (req_ready[c] !== 1'h1 && ++n < 200) @(negedge clk) #1;
        stop_if(n >= 200);
        @(posedge clk);
        d = req_store[c] ? req_wdata[c] : own_state[c] != 2'h0 ? own_rdata[c] : peer_state[c] == 2'h3
            ? peer_rdata[c] : l2_hit[c] ? l2_rdata[c] : {33'h0, 1'(c), req_addr[c]} ^ 64'hc3a5_0f96_1e2d_4b78;
        s = req_store[c] ? 2'h3 : peer_state[c] == 2'h0 ? 2'h2 : 2'h1;
        w = req_store[c] || own_state[c] == 2'h0;
        @(negedge clk);
        req_valid[c] = 1'h0;
        for (n = 0; n < 300 && resp_valid[c] !== 1'h1; n++) @(negedge clk);
        stop_if(n >= 300);
        check(resp_data[c], d);
        check(l1_wr_data[c], d);
        check({61'h0, l1_wr_en[c], w ? l1_wr_state[c] : 2'h0}, {61'h0, w, w ? s : 2'h0});
        check({34'h0, l1_wr_addr[c]}, {34'h0, req_addr[c]});
    endtask : access
    initial
    begin
        void'($urandom(32'h3b646ed0));
        set_core(0, 0, 0, 0);
        set_core(1, 0, 0, 0);
        repeat (4) @(negedge clk);
        rstn = 1'h1;
        fork
            repeat (60) access(0, -1, -1, -1);
            repeat (60) access(1, -1, -1, -1);
        join
        access(0, 0, 0, 3);
        access(0, 1, 2, 0);
        access(0, 1, 1, 3);
        repeat (40) @(negedge clk);
        give_verdict();
    end
endmodule : l2_share_ctrl_tb

// ==== verif/l2_share_sva.sv ====
// core 0 answer timing and line state checks
`timescale 1ns/100ps
module l2_share_sva (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [1:0] req_valid,
    input wire logic [1:0] req_ready,
    input wire logic [1:0] req_store,
    input wire logic [1:0] own_state [2],
    input wire logic [1:0] resp_valid,
    input wire logic [1:0] l1_wr_en,
    input wire logic [1:0] l1_wr_state [2],
    input wire logic [1:0] peer_share,
    input wire logic [1:0] peer_invalidate
);
    wire tk = req_valid[0] & req_ready[0];
    // a store without exclusive or modified ownership must go to the shared levels
    wire ms = tk & (req_store[0] ? !own_state[0][1] : own_state[0] == 2'h0);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ld_hit_a: assert property (tk && !req_store[0] && own_state[0] != 2'h0 |-> ##3 resp_valid[0])
        else $error("load hit late");
    st_hit_a: assert property (tk && req_store[0] && own_state[0][1]
        |-> ##2 resp_valid[0] && l1_wr_state[0] == 2'h3) else $error("store hit");
    wr_resp_a: assert property (l1_wr_en[0] |-> resp_valid[0]) else $error("lone write");
    miss_hold_a: assert property (ms |=> !req_ready[0]) else $error("ready in miss");
    miss_quiet_a: assert property (ms |-> ##3 (!resp_valid[0]) [*8]) else $error("miss early");
    miss_bound_a: assert property (ms |-> ##[15:120] resp_valid[0]) else $error("miss lost");
    share_a: assert property (peer_share[0] |-> resp_valid[0] && l1_wr_state[0] == 2'h1)
        else $error("share");
    inval_a: assert property (peer_invalidate[0] |-> resp_valid[0] && l1_wr_state[0] == 2'h3)
        else $error("invalidate");
    cover property (peer_share[0]);
    cover property (peer_invalidate[0]);
    cover property (ms);
endmodule : l2_share_sva
bind l2_share_ctrl l2_share_sva u_l2_share_sva (.*);

// ==== verilog/l2_share_ctrl.sv ====
// Contract
// - One second-level cache and bus interface are shared by both cores.
// - Data unit 32 KB 8-way; shared cache 2/4 MB, 8/16-way; 64-byte write-back lines.
// - Loads search own data unit, then peer with shared cache, then memory.
// - Peer supplies the line only when it holds it modified.
// - Stores first gain exclusive or modified state by the same search.
// - After ownership, store data is written and the line marked modified.
// - Ownership reads and writes happen after retirement, in retirement order.
// - Data unit hits: load 3 clocks, store 2, one access per clock (a store taken right after a load hit waits one clock).
// - Shared cache access takes about 14 clocks, one every 3 clocks.
// - Dirty victims are evicted alongside the fill, adding no requester latency (the core takes no new request until the write-back is granted the bus).
// - Victim write-back consumes shared cache slots and bus bandwidth.
`timescale 1ns/100ps
module l2_share_ctrl (
    input  wire logic                                 clk,
    input  wire logic                                 rstn,
    input  wire logic                                 ce,
    input  wire logic [l2_share_pkg::CORES-1:0]       req_valid,
    output logic      [l2_share_pkg::CORES-1:0]       req_ready,
    input  wire logic [l2_share_pkg::CORES-1:0]       req_store,
    input  wire logic [l2_share_pkg::LINE_ADDR_W-1:0] req_addr     [l2_share_pkg::CORES],
    input  wire logic [l2_share_pkg::DATA_W-1:0]      req_wdata    [l2_share_pkg::CORES],
    input  wire logic [1:0]                           own_state    [l2_share_pkg::CORES],
    input  wire logic [l2_share_pkg::DATA_W-1:0]      own_rdata    [l2_share_pkg::CORES],
    input  wire logic [1:0]                           peer_state   [l2_share_pkg::CORES],
    input  wire logic [l2_share_pkg::DATA_W-1:0]      peer_rdata   [l2_share_pkg::CORES],
    input  wire logic [l2_share_pkg::CORES-1:0]       l2_hit,
    input  wire logic [l2_share_pkg::DATA_W-1:0]      l2_rdata     [l2_share_pkg::CORES],
    input  wire logic [l2_share_pkg::CORES-1:0]       victim_dirty,
    input  wire logic [l2_share_pkg::LINE_ADDR_W-1:0] victim_addr  [l2_share_pkg::CORES],
    input  wire logic [l2_share_pkg::DATA_W-1:0]      victim_data  [l2_share_pkg::CORES],
    output logic      [l2_share_pkg::CORES-1:0]       resp_valid,
    output logic      [l2_share_pkg::DATA_W-1:0]      resp_data    [l2_share_pkg::CORES],
    output logic      [l2_share_pkg::CORES-1:0]       l1_wr_en,
    output logic      [l2_share_pkg::LINE_ADDR_W-1:0] l1_wr_addr   [l2_share_pkg::CORES],
    output logic      [l2_share_pkg::DATA_W-1:0]      l1_wr_data   [l2_share_pkg::CORES],
    output logic      [1:0]                           l1_wr_state  [l2_share_pkg::CORES],
    output logic      [l2_share_pkg::CORES-1:0]       peer_invalidate,
    output logic      [l2_share_pkg::CORES-1:0]       peer_share,
    output logic                                      mem_rd_valid,
    output logic      [l2_share_pkg::LINE_ADDR_W-1:0] mem_rd_addr,
    output logic      [l2_share_pkg::CORE_W-1:0]      mem_rd_core,
    input  wire logic                                 mem_done,
    input  wire logic [l2_share_pkg::DATA_W-1:0]      mem_rdata,
    output logic                                      mem_wb_valid,
    output logic      [l2_share_pkg::LINE_ADDR_W-1:0] mem_wb_addr,
    output logic      [l2_share_pkg::DATA_W-1:0]      mem_wb_data
);

    localparam int NREQ = 2 * l2_share_pkg::CORES;

    // requesters 0..CORES-1 are miss accesses, CORES..2*CORES-1 are victim write-backs
    logic [NREQ-1:0]                      l2_req;
    logic [NREQ-1:0]                      l2_gnt;
    logic [NREQ-1:0]                      bus_req;
    logic [NREQ-1:0]                      bus_gnt;
    logic [l2_share_pkg::LINE_ADDR_W-1:0] miss_addr [l2_share_pkg::CORES];
    logic [l2_share_pkg::LINE_ADDR_W-1:0] wb_addr   [l2_share_pkg::CORES];
    logic [l2_share_pkg::DATA_W-1:0]      wb_data   [l2_share_pkg::CORES];

    logic                                 bus_busy_reg;
    logic [l2_share_pkg::CORE_W-1:0]      mem_owner_reg;
    logic                                 rd_hit;
    logic [l2_share_pkg::LINE_ADDR_W-1:0] rd_addr_sel;
    logic [l2_share_pkg::CORE_W-1:0]      rd_core_sel;
    logic                                 wb_hit;
    logic [l2_share_pkg::LINE_ADDR_W-1:0] wb_addr_sel;
    logic [l2_share_pkg::DATA_W-1:0]      wb_data_sel;

    // one shared cache port, a new access every 3 clocks
    slot_pacer #(.N(NREQ), .GAP(l2_share_pkg::L2_GAP_CLK)) u_l2_port (
        .clk  (clk),
        .rstn (rstn),
        .ce   (ce),
        .req  (l2_req),
        .gnt  (l2_gnt)
    );

    // one shared bus interface for reads and victim write-backs
    slot_pacer #(.N(NREQ), .GAP(l2_share_pkg::BUS_GAP_CLK)) u_bus_port (
        .clk  (clk),
        .rstn (rstn),
        .ce   (ce),
        .req  (bus_req),
        .gnt  (bus_gnt)
    );

    for (genvar c = 0; c < l2_share_pkg::CORES; c++)
    begin : g_core
        l2_share_pkg::ctrl_state_type         state_reg;
        l2_share_pkg::ctrl_state_type         state_next;
        logic [l2_share_pkg::CNT_W-1:0]       cnt_reg;
        logic [1:0]                           src_reg;
        logic                                 store_reg;
        logic                                 peer_valid_reg;
        logic [l2_share_pkg::LINE_ADDR_W-1:0] addr_reg;
        logic [l2_share_pkg::DATA_W-1:0]      data_reg;
        logic                                 vdirty_reg;
        logic [l2_share_pkg::LINE_ADDR_W-1:0] vaddr_reg;
        logic [l2_share_pkg::DATA_W-1:0]      vdata_reg;
        logic                                 wb_pend_reg;
        logic                                 wb_bus_reg;
        logic [l2_share_pkg::LINE_ADDR_W-1:0] wb_addr_reg;
        logic [l2_share_pkg::DATA_W-1:0]      wb_data_reg;
        logic                                 pv_reg [l2_share_pkg::PIPE_DEPTH];
        logic [l2_share_pkg::META_W-1:0]      pm_reg [l2_share_pkg::PIPE_DEPTH];
        logic [l2_share_pkg::DATA_W-1:0]      pd_reg [l2_share_pkg::PIPE_DEPTH];
        logic [l2_share_pkg::LINE_ADDR_W-1:0] pa_reg [l2_share_pkg::PIPE_DEPTH];

        wire own_valid  = (own_state[c] != l2_share_pkg::LINE_INVALID);
        wire own_owned  = (own_state[c] == l2_share_pkg::LINE_EXCL) || (own_state[c] == l2_share_pkg::LINE_MOD);
        wire peer_mod   = (peer_state[c] == l2_share_pkg::LINE_MOD);
        wire peer_valid = (peer_state[c] != l2_share_pkg::LINE_INVALID);
        // a store hits only with the line owned, a load with any valid copy
        wire own_hit    = req_store[c] ? own_owned : own_valid;
        // a store may not land on a stage a load entered one clock earlier
        wire stall_st   = req_store[c] && pv_reg[0];
        // one miss at a time keeps misses and hits in retirement order
        assign req_ready[c] = ce && (state_reg == l2_share_pkg::ST_IDLE) && !wb_pend_reg && !stall_st;
        wire take       = req_valid[c] && req_ready[c];
        wire take_hit   = take && own_hit;
        wire take_miss  = take && !own_hit;
        // the peer copy wins only when modified; otherwise shared cache, then memory
        wire [1:0] fill_src = peer_mod ? l2_share_pkg::SRC_PEER :
                              (l2_hit[c] ? l2_share_pkg::SRC_L2 : l2_share_pkg::SRC_MEM);
        wire [l2_share_pkg::DATA_W-1:0] fill_data = peer_mod ? peer_rdata[c] : l2_rdata[c];
        wire cnt_done   = (cnt_reg == l2_share_pkg::CNT_ZERO);
        wire mem_mine   = (state_reg == l2_share_pkg::ST_MEM_WAIT) && mem_done
                          && (mem_owner_reg == l2_share_pkg::CORE_W'(c));
        wire inject     = ((state_reg == l2_share_pkg::ST_COUNT) && cnt_done && (src_reg != l2_share_pkg::SRC_MEM))
                          || mem_mine;
        wire [l2_share_pkg::DATA_W-1:0] inj_data = (mem_mine && !store_reg) ? mem_rdata : data_reg;
        // a store leaves the line modified; a load fill shares when the peer keeps a copy
        wire [1:0] fill_state = store_reg ? l2_share_pkg::LINE_MOD :
                                (peer_valid_reg ? l2_share_pkg::LINE_SHARED : l2_share_pkg::LINE_EXCL);
        // ownership for a store removes the peer copy
        wire inj_inv    = store_reg && peer_valid_reg;
        wire inj_shr    = !store_reg && (src_reg == l2_share_pkg::SRC_PEER);
        wire [l2_share_pkg::META_W-1:0] inj_meta = {1'b1, fill_state, inj_inv, inj_shr};
        wire [l2_share_pkg::META_W-1:0] hit_meta = {req_store[c], l2_share_pkg::LINE_MOD, 1'b0, 1'b0};
        wire [l2_share_pkg::DATA_W-1:0] hit_data = req_store[c] ? req_wdata[c] : own_rdata[c];

        assign l2_req[c]                        = (state_reg == l2_share_pkg::ST_L2_SLOT);
        assign bus_req[c]                       = (state_reg == l2_share_pkg::ST_BUS_SLOT) && !bus_busy_reg;
        // a victim write-back takes a shared cache slot, then a bus slot
        assign l2_req[l2_share_pkg::CORES + c]  = wb_pend_reg && !wb_bus_reg;
        assign bus_req[l2_share_pkg::CORES + c] = wb_pend_reg && wb_bus_reg;
        assign miss_addr[c]                     = addr_reg;
        assign wb_addr[c]                       = wb_addr_reg;
        assign wb_data[c]                       = wb_data_reg;

        // tiers visited in order: own unit, then peer with shared cache, then memory
        always_comb
        begin
            state_next = state_reg;
            case (state_reg)
                l2_share_pkg::ST_IDLE:
                    if (take_miss)
                        state_next = l2_share_pkg::ST_L2_SLOT;
                l2_share_pkg::ST_L2_SLOT:
                    if (l2_gnt[c])
                        state_next = l2_share_pkg::ST_COUNT;
                l2_share_pkg::ST_COUNT:
                    if (cnt_done)
                        state_next = (src_reg == l2_share_pkg::SRC_MEM) ? l2_share_pkg::ST_BUS_SLOT
                                                                        : l2_share_pkg::ST_IDLE;
                l2_share_pkg::ST_BUS_SLOT:
                    if (bus_gnt[c])
                        state_next = l2_share_pkg::ST_MEM_WAIT;
                l2_share_pkg::ST_MEM_WAIT:
                    if (mem_mine)
                        state_next = l2_share_pkg::ST_IDLE;
                default:
                    state_next = l2_share_pkg::ST_IDLE;
            endcase
        end

        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                state_reg      <= l2_share_pkg::ST_IDLE;
                cnt_reg        <= l2_share_pkg::CNT_ZERO;
                src_reg        <= l2_share_pkg::SRC_L2;
                store_reg      <= 1'b0;
                peer_valid_reg <= 1'b0;
                addr_reg       <= '0;
                data_reg       <= '0;
                vdirty_reg     <= 1'b0;
                vaddr_reg      <= '0;
                vdata_reg      <= '0;
            end
            else if (ce)
            begin
                state_reg <= state_next;
                if (take_miss)
                begin
                    src_reg        <= fill_src;
                    store_reg      <= req_store[c];
                    peer_valid_reg <= peer_valid;
                    addr_reg       <= req_addr[c];
                    data_reg       <= req_store[c] ? req_wdata[c] : fill_data;
                    vdirty_reg     <= victim_dirty[c];
                    vaddr_reg      <= victim_addr[c];
                    vdata_reg      <= victim_data[c];
                end
                // count the shared cache time, plus bus cycles for peer or memory
                if (l2_gnt[c])
                    cnt_reg <= (src_reg == l2_share_pkg::SRC_L2) ? l2_share_pkg::CNT_L2 : l2_share_pkg::CNT_PEER;
                else if (!cnt_done)
                    cnt_reg <= cnt_reg - 6'h01;
            end
        end

        // dirty victim queued as the fill lands, so the answer is not delayed
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                wb_pend_reg <= 1'b0;
                wb_bus_reg  <= 1'b0;
                wb_addr_reg <= '0;
                wb_data_reg <= '0;
            end
            else if (ce)
            begin
                if (inject && vdirty_reg)
                begin
                    wb_pend_reg <= 1'b1;
                    wb_bus_reg  <= 1'b0;
                    wb_addr_reg <= vaddr_reg;
                    wb_data_reg <= vdata_reg;
                end
                else if (bus_gnt[l2_share_pkg::CORES + c])
                    wb_pend_reg <= 1'b0;
                else if (l2_gnt[l2_share_pkg::CORES + c])
                    wb_bus_reg <= 1'b1;
            end
        end

        for (genvar i = 0; i < l2_share_pkg::PIPE_DEPTH; i++)
        begin : g_stage
            localparam int PI = (i == 0) ? 0 : i - 1;
            // loads enter three stages from the end, stores two, one per clock
            wire hit_here = take_hit && (i == (req_store[c] ? l2_share_pkg::STORE_ENTRY : 0));
            wire inj_here = inject && (i == l2_share_pkg::PIPE_LAST);
            wire prev_v   = (i != 0) && pv_reg[PI];
            wire nv       = hit_here || inj_here || prev_v;
            wire [l2_share_pkg::META_W-1:0]      nm = hit_here ? hit_meta : (inj_here ? inj_meta : pm_reg[PI]);
            wire [l2_share_pkg::DATA_W-1:0]      nd = hit_here ? hit_data : (inj_here ? inj_data : pd_reg[PI]);
            wire [l2_share_pkg::LINE_ADDR_W-1:0] na = hit_here ? req_addr[c] : (inj_here ? addr_reg : pa_reg[PI]);

            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    pv_reg[i] <= 1'b0;
                    pm_reg[i] <= '0;
                    pd_reg[i] <= '0;
                    pa_reg[i] <= '0;
                end
                else if (ce)
                begin
                    pv_reg[i] <= nv;
                    pm_reg[i] <= nm;
                    pd_reg[i] <= nd;
                    pa_reg[i] <= na;
                end
            end
        end

        // writes address whole 64-byte lines of the data unit
        assign l1_wr_addr[c]      = pa_reg[l2_share_pkg::PIPE_LAST];
        assign resp_valid[c]      = pv_reg[l2_share_pkg::PIPE_LAST];
        assign resp_data[c]       = pd_reg[l2_share_pkg::PIPE_LAST];
        assign l1_wr_data[c]      = pd_reg[l2_share_pkg::PIPE_LAST];
        // store data lands in the data unit with the line marked modified
        assign l1_wr_en[c]        = pv_reg[l2_share_pkg::PIPE_LAST] && pm_reg[l2_share_pkg::PIPE_LAST][l2_share_pkg::META_WR];
        assign l1_wr_state[c]     = pm_reg[l2_share_pkg::PIPE_LAST][l2_share_pkg::META_ST_LO +: 2];
        assign peer_invalidate[c] = pv_reg[l2_share_pkg::PIPE_LAST] && pm_reg[l2_share_pkg::PIPE_LAST][l2_share_pkg::META_INV];
        // a peer that supplied its modified line to a load keeps it shared
        assign peer_share[c]      = pv_reg[l2_share_pkg::PIPE_LAST] && pm_reg[l2_share_pkg::PIPE_LAST][l2_share_pkg::META_SHR];
    end

    // granted bus requester selects address and data for the outgoing transfer
    always_comb
    begin
        rd_hit      = 1'b0;
        rd_addr_sel = '0;
        rd_core_sel = '0;
        wb_hit      = 1'b0;
        wb_addr_sel = '0;
        wb_data_sel = '0;
        for (int c = 0; c < l2_share_pkg::CORES; c++)
        begin
            if (bus_gnt[c])
            begin
                rd_hit      = 1'b1;
                rd_addr_sel = miss_addr[c];
                rd_core_sel = l2_share_pkg::CORE_W'(c);
            end
            if (bus_gnt[l2_share_pkg::CORES + c])
            begin
                wb_hit      = 1'b1;
                wb_addr_sel = wb_addr[c];
                wb_data_sel = wb_data[c];
            end
        end
    end

    // a single memory read is outstanding; write-backs are posted around it
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bus_busy_reg  <= 1'b0;
            mem_owner_reg <= '0;
            mem_rd_valid  <= 1'b0;
            mem_rd_addr   <= '0;
            mem_rd_core   <= '0;
            mem_wb_valid  <= 1'b0;
            mem_wb_addr   <= '0;
            mem_wb_data   <= '0;
        end
        else if (ce)
        begin
            if (rd_hit)
            begin
                bus_busy_reg  <= 1'b1;
                mem_owner_reg <= rd_core_sel;
                mem_rd_addr   <= rd_addr_sel;
                mem_rd_core   <= rd_core_sel;
            end
            else if (mem_done)
                bus_busy_reg <= 1'b0;
            mem_rd_valid <= rd_hit;
            // victim data goes out over the bus
            mem_wb_valid <= wb_hit;
            if (wb_hit)
            begin
                mem_wb_addr <= wb_addr_sel;
                mem_wb_data <= wb_data_sel;
            end
        end
    end

endmodule : l2_share_ctrl

// ==== verilog/l2_share_pkg.sv ====
// constants and types shared by the dual-core second-level cache controller
package l2_share_pkg;

    // two cores share one second-level cache and one bus interface
    localparam int CORES           = 2;
    localparam int CORE_W          = 1;

    // first-level data unit geometry: 32 KB, 8 ways, 64-byte lines, write-back
    localparam int LINE_BYTES      = 64;
    localparam int L1_SIZE_KB      = 32;
    localparam int L1_WAYS         = 8;
    localparam int L1_SETS         = L1_SIZE_KB * 1024 / (LINE_BYTES * L1_WAYS);

    // shared second-level cache: 2 or 4 MB, 8 or 16 ways, 64-byte lines, write-back
    localparam int L2_SIZE_MB      = 4;
    localparam int L2_WAYS         = 16;
    localparam int L2_SETS         = L2_SIZE_MB * 1024 * 1024 / (LINE_BYTES * L2_WAYS);

    // physical address split into line address and byte offset
    localparam int PADDR_W         = 36;
    localparam int OFFSET_W        = 6;
    localparam int LINE_ADDR_W     = PADDR_W - OFFSET_W;
    localparam int DATA_W          = 64;

    // line states held by a first-level data unit
    localparam logic [1:0] LINE_INVALID = 2'h0;
    localparam logic [1:0] LINE_SHARED  = 2'h1;
    localparam logic [1:0] LINE_EXCL    = 2'h2;
    localparam logic [1:0] LINE_MOD     = 2'h3;

    // where a missing line is sourced from
    localparam logic [1:0] SRC_L2   = 2'h1;
    localparam logic [1:0] SRC_PEER = 2'h2;
    localparam logic [1:0] SRC_MEM  = 2'h3;

    // latencies and throughputs in core clocks
    localparam int LOAD_HIT_CLK    = 3;
    localparam int STORE_HIT_CLK   = 2;
    localparam int L2_LAT_CLK      = 14;
    localparam int L2_GAP_CLK      = 3;
    localparam int BUS_GAP_CLK     = 1;
    // 5.5 bus cycles, kept as half cycles so the figure stays exact
    localparam int BUS_HALF_CYCLES = 11;
    localparam int CLK_PER_BUS_CYC = 2;
    localparam int PEER_EXTRA_CLK  = BUS_HALF_CYCLES * CLK_PER_BUS_CYC / 2;
    localparam int PEER_LAT_CLK    = L2_LAT_CLK + PEER_EXTRA_CLK;

    // counter loads: the counter ends one clock before the answer appears
    localparam int CNT_W           = 6;
    localparam logic [CNT_W-1:0] CNT_L2   = CNT_W'(L2_LAT_CLK - 2);
    localparam logic [CNT_W-1:0] CNT_PEER = CNT_W'(PEER_LAT_CLK - 2);
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

    // hit pipeline: loads enter stage 0, stores one stage later, answers leave the last
    localparam int PIPE_DEPTH      = LOAD_HIT_CLK;
    localparam int PIPE_LAST       = PIPE_DEPTH - 1;
    localparam int STORE_ENTRY     = LOAD_HIT_CLK - STORE_HIT_CLK;

    // answer side-information field layout
    localparam int META_SHR        = 0;
    localparam int META_INV        = 1;
    localparam int META_ST_LO      = 2;
    localparam int META_WR         = 4;
    localparam int META_W          = 5;

    // miss handling sequence of one core
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_L2_SLOT,
        ST_COUNT,
        ST_BUS_SLOT,
        ST_MEM_WAIT
    } ctrl_state_type;

endpackage : l2_share_pkg

// ==== verilog/slot_pacer.sv ====
// round-robin grant of a shared port with a least spacing between grants
`timescale 1ns/100ps
module slot_pacer #(
    parameter int N   = 4,
    parameter int GAP = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic [N-1:0] req,
    output logic      [N-1:0] gnt
);

    logic [3:0]           gap_reg;
    logic [$clog2(N)-1:0] last_reg;
    logic [$clog2(N)-1:0] win_idx;
    wire                  open_slot = (gap_reg == 4'h0);
    wire                  any_gnt   = |gnt;

    // one grant per open slot, searching from the requester after the last winner
    always_comb
    begin
        int  idx;
        logic found;
        idx     = 0;
        found   = 1'b0;
        gnt     = '0;
        win_idx = last_reg;
        for (int i = 1; i <= N; i++)
        begin
            idx = (int'(last_reg) + i) % N;
            if (!found && open_slot && ce && req[idx])
            begin
                gnt[idx] = 1'b1;
                win_idx  = ($clog2(N))'(idx);
                found    = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gap_reg  <= 4'h0;
            last_reg <= '0;
        end
        else if (ce)
        begin
            if (any_gnt)
            begin
                gap_reg  <= 4'(GAP - 1);
                last_reg <= win_idx;
            end
            else if (!open_slot)
            begin
                gap_reg <= gap_reg - 4'h1;
            end
        end
    end

endmodule : slot_pacer
